// ### verilog/phy_strap_pkg.sv
// Purpose: Shared constants for the strap latch and shared pin control.
// Assumes: One clock domain, clk_sys at 125 MHz.
// Notes:   Strap vector layout, pin indices and lamp source codes live here.
package phy_strap_pkg;

   // ********************************************************
   // Strap vector layout
   // ********************************************************
   localparam int unsigned STRAP_W       = 11;              // Bits in the latched strap vector
   localparam int unsigned POS_ADDR_LO   = 0;               // Management address bits 3..0
   localparam int unsigned POS_ADDR_HI   = 3;
   localparam int unsigned POS_RXTRI     = 4;               // Receive isolation strap
   localparam int unsigned POS_DUPLEX    = 5;               // 1 = full duplex
   localparam int unsigned POS_RMII      = 6;               // 1 = reduced interface mode
   localparam int unsigned POS_NODE      = 7;               // 0 = node mode
   localparam int unsigned POS_AUTONEG   = 8;               // 1 = autonegotiation on
   localparam int unsigned POS_SPEED     = 9;               // 1 = 100M
   localparam int unsigned POS_XOVER     = 10;              // 1 = crossover correction on
   localparam logic [10:0] STRAP_RESET   = 11'h000;         // Value held until the latch edge

   // ********************************************************
   // Shared pin indices
   // ********************************************************
   localparam int unsigned PIN_N         = 7;               // Shared output-capable pins
   localparam int unsigned PIN_IRQ       = 0;
   localparam int unsigned PIN_LAMP0     = 1;
   localparam int unsigned PIN_LAMP1     = 2;
   localparam int unsigned PIN_RXD1      = 3;
   localparam int unsigned PIN_RXD0      = 4;
   localparam int unsigned PIN_CRSDV     = 5;
   localparam int unsigned PIN_RXER      = 6;
   localparam logic [6:0]  OE_N_OFF      = 7'h7f;           // All drivers released
   localparam logic [6:0]  PIN_O_RESET   = 7'h00;

   // ********************************************************
   // Lamp sources and event mask
   // ********************************************************
   localparam int unsigned EV_N          = 8;               // Selectable interrupt events
   localparam logic [1:0]  LAMP_ACTIVITY = 2'h0;
   localparam logic [1:0]  LAMP_SPEED    = 2'h1;
   localparam logic [1:0]  LAMP_LINK     = 2'h2;
   localparam logic [1:0]  LAMP_DUPLEX   = 2'h3;
   localparam logic [1:0]  LAMP0_DEFAULT = LAMP_ACTIVITY;   // Suggested cfg value for lamp 0
   localparam logic [1:0]  LAMP1_DEFAULT = LAMP_SPEED;      // Suggested cfg value for lamp 1

   // Bring-up sequence
   typedef enum logic [1:0] {
      ST_HOLD,
      ST_RUN
   } seq_state_t;

endpackage

// ### verilog/strap_capture.sv
// Purpose: Register bank that captures a vector once and holds it.
// Assumes: capture is a single-cycle pulse from the sequencer.
// Notes:   The async reset loads a constant; pin levels are taken on a clock edge only.
module strap_capture (
   input  wire logic                             clk_sys,
   input  wire logic                             arst_n,
   input  wire logic                             capture,
   input  wire logic [phy_strap_pkg::STRAP_W-1:0] d,
   output logic      [phy_strap_pkg::STRAP_W-1:0] q
);

   // ********************************************************
   // Capture register
   // ********************************************************
   // Loaded once per reset; stays frozen until the next reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q <= phy_strap_pkg::STRAP_RESET;
      end else if (capture) begin
         q <= d;
      end
   end

endmodule

// ### verilog/phy_strap_latch_pin_mux.sv
// Purpose: Strap sampling and dual-function pin control for a 10/100 PHY.
// Assumes: All pin inputs are synchronous to clk_sys; pin pads resolve oe_n.
// Notes:   Straps taken at the first edge after release, while drivers are off.
// Notes on behaviour
// - Low reset input resets all internal logic.
// - Address bit 2 strap, then interrupt output.
// - Four-bit management address captured at reset.
// - Address-0 pin becomes lamp 0, activity default.
// - Address-1 pin becomes lamp 1, speed default.
// - Address-1 pin may act as isolate input.
// - Receive isolation strap from receive bit 1.
// - Duplex strap from receive data bit 0.
// - Reduced interface strap from data-valid pin.
// - Node strap from receive error pin, board low.
// - Autonegotiation strap from its own pin.
// - Speed strap from its own pin.
// - Crossover strap from its own pin.
// - Configuration goes over the management bus.
// - Interrupt raised for eight selectable events.
// - Isolation strap high disables lamp 1.
// - Speed and duplex straps ignored under autonegotiation.
// - Two receive bits per data-valid cycle.
// - Two transmit bits per enable cycle.
module phy_strap_latch_pin_mux (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Dedicated strap inputs
   input  wire logic        addr3_strap_pin,
   input  wire logic        autoneg_strap,
   input  wire logic        speed_strap,
   input  wire logic        crossover_strap,
   // Shared pins: input, output, output enable (low = driving)
   input  wire logic        addr2_irq_pin_i,
   output logic             addr2_irq_pin_o,
   output logic             addr2_irq_pin_oe_n,
   input  wire logic        addr0_lamp0_pin_i,
   output logic             addr0_lamp0_pin_o,
   output logic             addr0_lamp0_pin_oe_n,
   input  wire logic        addr1_isolate_lamp1_pin_i,
   output logic             addr1_isolate_lamp1_pin_o,
   output logic             addr1_isolate_lamp1_pin_oe_n,
   input  wire logic        rx_tristate_strap_pin_i,
   output logic             rx_tristate_strap_pin_o,
   output logic             rx_tristate_strap_pin_oe_n,
   input  wire logic        duplex_strap_pin_i,
   output logic             duplex_strap_pin_o,
   output logic             duplex_strap_pin_oe_n,
   input  wire logic        reduced_if_select_pin_i,
   output logic             reduced_if_select_pin_o,
   output logic             reduced_if_select_pin_oe_n,
   input  wire logic        node_select_strap_pin_i,
   output logic             node_select_strap_pin_o,
   output logic             node_select_strap_pin_oe_n,
   // Transmit side from the MAC
   input  wire logic        tx_en_pin,
   input  wire logic [1:0]  txd_pin,
   output logic             core_tx_en,
   output logic [1:0]       core_txd,
   // Receive side from the PHY core
   input  wire logic [1:0]  core_rxd,
   input  wire logic        core_crs_dv,
   input  wire logic        core_rx_er,
   // Interrupt events and configuration
   input  wire logic [7:0]  ev_in,
   input  wire logic [7:0]  ev_enable,
   input  wire logic        irq_active_high,
   // Lamp configuration and sources
   input  wire logic [1:0]  lamp0_sel,
   input  wire logic [1:0]  lamp1_sel,
   input  wire logic        lamp_activity,
   input  wire logic        lamp_speed100,
   input  wire logic        lamp_link,
   input  wire logic        lamp_duplex,
   // Latched configuration toward the core
   output logic             straps_valid,
   output logic [3:0]       strap_phy_addr,
   output logic             strap_rmii_mode,
   output logic             strap_node_sel,
   output logic             strap_autoneg_en,
   output logic             strap_crossover_en,
   output logic             strap_rx_tristate,
   output logic             forced_speed100,
   output logic             forced_full_duplex,
   output logic             rx_isolate
);
   // ********************************************************
   // Declarations
   // ********************************************************
   phy_strap_pkg::seq_state_t state_r;                     // Bring-up sequencer
   logic [10:0]               strap_d;                     // Pin levels at the latch edge
   logic [10:0]               strap_q;                     // Latched straps
   logic                      capture;                     // Latch pulse
   logic [6:0]                pin_o_r;                     // Shared pin output data
   logic [6:0]                oe_n_r;                      // Shared pin output enables
   logic [6:0]                oe_n_nxt;
   logic                      tx_en_r;
   logic [1:0]                txd_r;
   logic                      isolate_r;                   // Sampled isolate input
   logic                      ev_hit;                      // Any enabled event active
   // Pick a lamp source from its select code
   function automatic logic lamp_pick(input logic [1:0] sel, input logic act,
                                      input logic spd, input logic lnk, input logic dpx);
      logic r;
      r = act;
      if (sel == phy_strap_pkg::LAMP_SPEED) begin
         r = spd;
      end else if (sel == phy_strap_pkg::LAMP_LINK) begin
         r = lnk;
      end else if (sel == phy_strap_pkg::LAMP_DUPLEX) begin
         r = dpx;
      end
      return r;
   endfunction
   // ********************************************************
   // Sequencer and strap sampling
   // ********************************************************
   // Hold until the first edge after release, then run for good
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= phy_strap_pkg::ST_HOLD;
      end else begin
         case (state_r)
            phy_strap_pkg::ST_HOLD: state_r <= phy_strap_pkg::ST_RUN;
            default:                state_r <= phy_strap_pkg::ST_RUN;
         endcase
      end
   end
   assign capture = (state_r == phy_strap_pkg::ST_HOLD);
   // Drivers are still released in ST_HOLD, so pins show board straps
   always_comb begin
      strap_d                                = '0;
      strap_d[phy_strap_pkg::POS_ADDR_LO]    = addr0_lamp0_pin_i;
      strap_d[phy_strap_pkg::POS_ADDR_LO+1]  = addr1_isolate_lamp1_pin_i;
      strap_d[phy_strap_pkg::POS_ADDR_LO+2]  = addr2_irq_pin_i;
      strap_d[phy_strap_pkg::POS_ADDR_HI]    = addr3_strap_pin;
      strap_d[phy_strap_pkg::POS_RXTRI]      = rx_tristate_strap_pin_i;
      strap_d[phy_strap_pkg::POS_DUPLEX]     = duplex_strap_pin_i;
      strap_d[phy_strap_pkg::POS_RMII]       = reduced_if_select_pin_i;
      strap_d[phy_strap_pkg::POS_NODE]       = node_select_strap_pin_i;
      strap_d[phy_strap_pkg::POS_AUTONEG]    = autoneg_strap;
      strap_d[phy_strap_pkg::POS_SPEED]      = speed_strap;
      strap_d[phy_strap_pkg::POS_XOVER]      = crossover_strap;
   end
   // Capture once per reset and hold until the next one
   strap_capture u_strap_capture (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .capture (capture),
      .d       (strap_d),
      .q       (strap_q)
   );
   // Latched values; address feeds the management slave of the core
   assign straps_valid       = (state_r == phy_strap_pkg::ST_RUN);
   assign strap_phy_addr     = strap_q[phy_strap_pkg::POS_ADDR_HI:phy_strap_pkg::POS_ADDR_LO];
   assign strap_rmii_mode    = strap_q[phy_strap_pkg::POS_RMII];
   assign strap_node_sel     = strap_q[phy_strap_pkg::POS_NODE];
   assign strap_autoneg_en   = strap_q[phy_strap_pkg::POS_AUTONEG];
   assign strap_crossover_en = strap_q[phy_strap_pkg::POS_XOVER];
   assign strap_rx_tristate  = strap_q[phy_strap_pkg::POS_RXTRI];
   // Autonegotiation overrides the forced speed and duplex straps
   assign forced_speed100    = strap_q[phy_strap_pkg::POS_SPEED] & ~strap_autoneg_en;
   assign forced_full_duplex = strap_q[phy_strap_pkg::POS_DUPLEX] & ~strap_autoneg_en;
   // ********************************************************
   // Output enables
   // ********************************************************
   // Lamp 1 driver stays off when its pin serves as the isolate input
   always_comb begin
      oe_n_nxt = phy_strap_pkg::OE_N_OFF;
      if (state_r == phy_strap_pkg::ST_RUN) begin
         oe_n_nxt                           = '0;
         oe_n_nxt[phy_strap_pkg::PIN_LAMP1] = strap_rx_tristate;
         if (isolate_r) begin
            // Isolated receiver releases its four output pins
            oe_n_nxt[phy_strap_pkg::PIN_RXD1]  = 1'b1;
            oe_n_nxt[phy_strap_pkg::PIN_RXD0]  = 1'b1;
            oe_n_nxt[phy_strap_pkg::PIN_CRSDV] = 1'b1;
            oe_n_nxt[phy_strap_pkg::PIN_RXER]  = 1'b1;
         end
      end
   end
   // Drivers come on one edge after the latch, never during reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         oe_n_r <= phy_strap_pkg::OE_N_OFF;
      end else begin
         oe_n_r <= oe_n_nxt;
      end
   end
   // Isolate input, only live when the isolation strap was latched high
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         isolate_r <= 1'b0;
      end else begin
         isolate_r <= straps_valid & strap_rx_tristate & addr1_isolate_lamp1_pin_i;
      end
   end
   assign rx_isolate = isolate_r;
   // ********************************************************
   // Run-time pin data
   // ********************************************************
   assign ev_hit = |(ev_in & ev_enable);
   // One register per shared pin keeps data outputs glitch free
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_o_r <= phy_strap_pkg::PIN_O_RESET;
      end else begin
         // Polarity chosen by configuration, low active by default
         pin_o_r[phy_strap_pkg::PIN_IRQ]   <= irq_active_high ? ev_hit : ~ev_hit;
         pin_o_r[phy_strap_pkg::PIN_LAMP0] <= lamp_pick(lamp0_sel, lamp_activity,
                                              lamp_speed100, lamp_link, lamp_duplex);
         pin_o_r[phy_strap_pkg::PIN_LAMP1] <= lamp_pick(lamp1_sel, lamp_activity,
                                              lamp_speed100, lamp_link, lamp_duplex);
         // Data bits follow data valid; quiet zeros otherwise
         pin_o_r[phy_strap_pkg::PIN_RXD1]  <= core_crs_dv & core_rxd[1];
         pin_o_r[phy_strap_pkg::PIN_RXD0]  <= core_crs_dv & core_rxd[0];
         pin_o_r[phy_strap_pkg::PIN_CRSDV] <= core_crs_dv;
         pin_o_r[phy_strap_pkg::PIN_RXER]  <= core_rx_er;
      end
   end

   assign addr2_irq_pin_o              = pin_o_r[phy_strap_pkg::PIN_IRQ];
   assign addr2_irq_pin_oe_n           = oe_n_r[phy_strap_pkg::PIN_IRQ];
   assign addr0_lamp0_pin_o            = pin_o_r[phy_strap_pkg::PIN_LAMP0];
   assign addr0_lamp0_pin_oe_n         = oe_n_r[phy_strap_pkg::PIN_LAMP0];
   assign addr1_isolate_lamp1_pin_o    = pin_o_r[phy_strap_pkg::PIN_LAMP1];
   assign addr1_isolate_lamp1_pin_oe_n = oe_n_r[phy_strap_pkg::PIN_LAMP1];
   assign rx_tristate_strap_pin_o      = pin_o_r[phy_strap_pkg::PIN_RXD1];
   assign rx_tristate_strap_pin_oe_n   = oe_n_r[phy_strap_pkg::PIN_RXD1];
   assign duplex_strap_pin_o           = pin_o_r[phy_strap_pkg::PIN_RXD0];
   assign duplex_strap_pin_oe_n        = oe_n_r[phy_strap_pkg::PIN_RXD0];
   assign reduced_if_select_pin_o      = pin_o_r[phy_strap_pkg::PIN_CRSDV];
   assign reduced_if_select_pin_oe_n   = oe_n_r[phy_strap_pkg::PIN_CRSDV];
   assign node_select_strap_pin_o      = pin_o_r[phy_strap_pkg::PIN_RXER];
   assign node_select_strap_pin_oe_n   = oe_n_r[phy_strap_pkg::PIN_RXER];
   // Transmit capture: two bits taken from the MAC on every enabled cycle; gated until run
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_en_r <= 1'b0;
         txd_r   <= 2'h0;
      end else begin
         tx_en_r <= straps_valid & tx_en_pin;
         txd_r   <= (straps_valid & tx_en_pin) ? txd_pin : 2'h0;
      end
   end
   assign core_tx_en = tx_en_r;
   assign core_txd   = txd_r;
   // ********************************************************
   // Assertions
   // ********************************************************
   property p_strap_hold;
      @(posedge clk_sys) disable iff (!arst_n)
      (state_r == phy_strap_pkg::ST_RUN) |=> $stable(strap_q);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("straps changed after latch");
   property p_addr_latch;
      @(posedge clk_sys) disable iff (!arst_n)
      capture |=> strap_phy_addr == {$past(addr3_strap_pin), $past(addr2_irq_pin_i),
                                     $past(addr1_isolate_lamp1_pin_i),
                                     $past(addr0_lamp0_pin_i)};
   endproperty
   a_addr_latch: assert property (p_addr_latch) else $error("address strap mismatch");
   // Drivers stay released through the latch edge and come on at the next one
   property p_quiet_reset;
      @(posedge clk_sys) disable iff (!arst_n)
      capture |=> (oe_n_r == phy_strap_pkg::OE_N_OFF) ##1 !oe_n_r[phy_strap_pkg::PIN_IRQ];
   endproperty
   a_quiet_reset: assert property (p_quiet_reset) else $error("driver timing wrong");
   property p_irq_pol;
      @(posedge clk_sys) disable iff (!arst_n)
      straps_valid |=> addr2_irq_pin_o == ($past(ev_hit) ~^ $past(irq_active_high));
   endproperty
   a_irq_pol: assert property (p_irq_pol) else $error("interrupt level wrong");
   property p_lamp1_off;
      @(posedge clk_sys) disable iff (!arst_n)
      (straps_valid && strap_rx_tristate) |=> addr1_isolate_lamp1_pin_oe_n;
   endproperty
   a_lamp1_off: assert property (p_lamp1_off) else $error("lamp 1 driven in isolate mode");
   property p_rx_dibit;
      @(posedge clk_sys) disable iff (!arst_n)
      core_crs_dv |=> reduced_if_select_pin_o &&
                      {rx_tristate_strap_pin_o, duplex_strap_pin_o} == $past(core_rxd);
   endproperty
   a_rx_dibit: assert property (p_rx_dibit) else $error("receive dibit lost");
   property p_tx_dibit;
      @(posedge clk_sys) disable iff (!arst_n)
      (straps_valid && tx_en_pin) |=> core_tx_en && core_txd == $past(txd_pin);
   endproperty
   a_tx_dibit: assert property (p_tx_dibit) else $error("transmit dibit lost");
   property p_forced;
      @(posedge clk_sys) disable iff (!arst_n)
      strap_autoneg_en |-> !forced_speed100 && !forced_full_duplex;
   endproperty
   a_forced: assert property (p_forced) else $error("forced mode under autoneg");
endmodule

// ### sim/board_mac_model.sv
// Purpose: Board straps, pad resolution and MAC transmit side for the pin mux.
// Assumes: Bench changes send and dibit on the falling edge of clk_sys.
// Notes:   Released pads read the board strap level, driven pads their output.
module board_mac_model (
   input  wire logic       clk_sys,
   input  wire logic [6:0] strap_lvl,
   input  wire logic [6:0] pin_o,
   input  wire logic [6:0] pin_oe_n,
   output logic      [6:0] pin_i,
   input  wire logic       send,
   input  wire logic [1:0] dibit,
   output logic            tx_en_pin,
   output logic [1:0]      txd_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************************************
   // Pads and transmit drive
   // ********************************************************
   // Pull level wins only while the device has let go of the pad
   assign pin_i = (pin_oe_n & strap_lvl) | (~pin_oe_n & pin_o);
   // Request held for a whole clk_sys period, set off the sampling edge
   assign tx_en_pin = send;
   // Idle data is inverted so a stale dibit cannot pass for a fresh one
   assign txd_pin = send ? dibit : ~dibit;
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the strap latch and shared pin control.
// Assumes: clk_sys at 125 MHz, inputs driven on the falling edge.
// Notes:   Two resets with different straps; the second lands mid-run.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] ev;   // Event levels
      logic [7:0] en;   // Event mask
      logic       pol;  // Interrupt polarity
      logic [1:0] s0;   // Lamp 0 source
      logic [1:0] s1;   // Lamp 1 source
      logic [3:0] src;  // {duplex, link, speed, activity}
      logic       crs;  // Receive data valid
      logic [1:0] rxd;  // Receive dibit
      logic       er;   // Receive error
      logic       irq;  // Expected interrupt pin
   } row_t;
   logic       clk_sys, arst_n, send, pol, a3, an, spd, xo, crs, er;
   logic [1:0] dibit, s0, s1, rxd, txd_pin, core_txd, ld;
   logic [6:0] strap_lvl, pin_o, pin_oe_n, pin_i;
   logic [7:0] ev, en;
   logic [3:0] src, addr;
   logic       tx_en_pin, core_tx_en, sv, rmii, node, ane, xoe, tri_s, f100, ffd, iso;
   int         n_mismatch = 0;
   int         n_checks = 0;
   row_t       rows [8];
   // ********************************************************
   // Design, board and clock
   // ********************************************************
   phy_strap_latch_pin_mux u_phy_strap_latch_pin_mux (
      .clk_sys(clk_sys), .arst_n(arst_n), .addr3_strap_pin(a3), .autoneg_strap(an),
      .speed_strap(spd), .crossover_strap(xo),
      .addr2_irq_pin_i(pin_i[0]), .addr2_irq_pin_o(pin_o[0]), .addr2_irq_pin_oe_n(pin_oe_n[0]),
      .addr0_lamp0_pin_i(pin_i[1]), .addr0_lamp0_pin_o(pin_o[1]),
      .addr0_lamp0_pin_oe_n(pin_oe_n[1]), .addr1_isolate_lamp1_pin_i(pin_i[2]),
      .addr1_isolate_lamp1_pin_o(pin_o[2]), .addr1_isolate_lamp1_pin_oe_n(pin_oe_n[2]),
      .rx_tristate_strap_pin_i(pin_i[3]), .rx_tristate_strap_pin_o(pin_o[3]),
      .rx_tristate_strap_pin_oe_n(pin_oe_n[3]), .duplex_strap_pin_i(pin_i[4]),
      .duplex_strap_pin_o(pin_o[4]), .duplex_strap_pin_oe_n(pin_oe_n[4]),
      .reduced_if_select_pin_i(pin_i[5]), .reduced_if_select_pin_o(pin_o[5]),
      .reduced_if_select_pin_oe_n(pin_oe_n[5]), .node_select_strap_pin_i(pin_i[6]),
      .node_select_strap_pin_o(pin_o[6]), .node_select_strap_pin_oe_n(pin_oe_n[6]),
      .tx_en_pin(tx_en_pin), .txd_pin(txd_pin), .core_tx_en(core_tx_en), .core_txd(core_txd),
      .core_rxd(rxd), .core_crs_dv(crs), .core_rx_er(er), .ev_in(ev), .ev_enable(en),
      .irq_active_high(pol), .lamp0_sel(s0), .lamp1_sel(s1), .lamp_activity(src[0]),
      .lamp_speed100(src[1]), .lamp_link(src[2]), .lamp_duplex(src[3]), .straps_valid(sv),
      .strap_phy_addr(addr), .strap_rmii_mode(rmii), .strap_node_sel(node),
      .strap_autoneg_en(ane), .strap_crossover_en(xoe), .strap_rx_tristate(tri_s),
      .forced_speed100(f100), .forced_full_duplex(ffd), .rx_isolate(iso));
   board_mac_model u_board_mac_model (
      .clk_sys(clk_sys), .strap_lvl(strap_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .pin_i(pin_i), .send(send), .dibit(dibit), .tx_en_pin(tx_en_pin), .txd_pin(txd_pin));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ********************************************************
   // Checking and closing
   // ********************************************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Hang guard: the sequence needs about 44 cycles
   initial begin
      #(3000 * 8);
      n_mismatch++;
      end_sim();
   end
   // Reset with given straps; pads change after capture and must be ignored
   task automatic do_reset(input logic [6:0] lvl, input logic [3:0] ded);
      @(negedge clk_sys);
      arst_n = 1'b0;
      strap_lvl = lvl;
      {a3, an, spd, xo} = ded;
      send = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("oe_rst", 16'h7f, {9'h0, pin_oe_n});
      chk("tx_rst", 16'h0, {14'h0, core_tx_en, sv});
      arst_n = 1'b0 | 1'b1;
      @(negedge clk_sys);
      send = 1'b0;
      strap_lvl = ~lvl & 7'h3b;
      {a3, an, spd, xo} = ~ded;
      @(negedge clk_sys);
   endtask
   // ********************************************************
   // Sequence
   // ********************************************************
   initial begin
      rows = '{'{8'h01, 8'h01, 1'b0, 2'h0, 2'h1, 4'h1, 1'b1, 2'h2, 1'b0, 1'b0},
               '{8'h02, 8'hfd, 1'b0, 2'h1, 2'h2, 4'h2, 1'b1, 2'h1, 1'b1, 1'b1},
               '{8'h04, 8'hff, 1'b1, 2'h2, 2'h3, 4'h4, 1'b0, 2'h3, 1'b0, 1'b1},
               '{8'h08, 8'h08, 1'b1, 2'h3, 2'h0, 4'h8, 1'b1, 2'h3, 1'b1, 1'b1},
               '{8'h10, 8'h00, 1'b1, 2'h0, 2'h1, 4'he, 1'b0, 2'h0, 1'b0, 1'b0},
               '{8'h20, 8'h20, 1'b0, 2'h1, 2'h2, 4'hd, 1'b1, 2'h0, 1'b0, 1'b0},
               '{8'h40, 8'h40, 1'b1, 2'h2, 2'h3, 4'hb, 1'b1, 2'h1, 1'b1, 1'b1},
               '{8'h80, 8'h7f, 1'b0, 2'h3, 2'h0, 4'h7, 1'b0, 2'h2, 1'b0, 1'b1}};
      arst_n = 1'b0;
      {send, dibit, ev, en, pol, s0, s1, src, crs, rxd, er} = '0;
      strap_lvl = 7'h32;
      {a3, an, spd, xo} = 4'hb;
      do_reset(7'h32, 4'hb);
      chk("straps1", 16'h4cb, {addr, rmii, node, ane, xoe, tri_s, f100, ffd});
      chk("oe_run", 16'h0, {9'h0, pin_oe_n});
      // Back-to-back dibits from the MAC
      for (int k = 2; k < 4; k++) begin
         send = 1'b1;
         dibit = 2'(k);
         @(negedge clk_sys);
         chk("tx", 16'(4 + k), {13'h0, core_tx_en, core_txd});
      end
      send = 1'b0;
      foreach (rows[k]) begin
         {ev, en, pol, s0, s1, src, crs, rxd, er} = rows[k][29:1];
         @(negedge clk_sys);
         chk("irq", 16'(rows[k].irq), 16'(pin_o[0]));
         chk("lamp0", 16'(src[s0]), 16'(pin_o[1]));
         chk("lamp1", 16'(src[s1]), 16'(pin_o[2]));
         chk("rx", 16'({er, crs, crs & rxd[0], crs & rxd[1]}), 16'(pin_o[6:3]));
         chk("iso0", 16'h0, 16'(iso));
      end
      // Mid-run reset with isolation and autonegotiation strapped on
      do_reset(7'h2b, 4'h6);
      chk("straps2", 16'h2d4, {addr, rmii, node, ane, xoe, tri_s, f100, ffd});
      for (int k = 0; k < 4; k++) begin
         ld = 2'(k);
         strap_lvl[2] = ld[0];
         repeat (3) @(negedge clk_sys);
         chk("iso", 16'(ld[0]), 16'(iso));
         chk("oe_iso", {11'h0, {4{ld[0]}}, 1'b1}, {11'h0, pin_oe_n[6:2]});
      end
      end_sim();
   end
endmodule
